// *** demand_channel.v ***
// one demand averaging channel with optional peak hold
`timescale 1ns/1ps
module demand_channel #(
    parameter W     = 16,
    parameter CW    = 16,
    parameter SLOTS = 4,
    parameter PEAK  = 1
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          ce,
    input  wire          sample_stb,
    input  wire [W-1:0]  sample,
    input  wire          sliding,
    input  wire          edge_mode,
    input  wire [CW-1:0] duration,
    input  wire          period_edge,
    input  wire          clear,
    output reg  [W-1:0]  avg_r,
    output reg  [W-1:0]  peak_r
);
    localparam SW = W + CW;
    localparam LS = (SLOTS > 1) ? $clog2(SLOTS) : 1;
    localparam TW = SW + LS;
    localparam DW = CW + LS;
    localparam QC = $clog2(TW + 1);

    // ----------------
    // accumulation of the running period
    // ----------------
    reg  [SW-1:0] sum_r;
    reg  [CW-1:0] cnt_r;
    reg  [CW-1:0] tick_r;
    reg  [SW-1:0] slot_sum [0:SLOTS-1];
    reg  [CW-1:0] slot_cnt [0:SLOTS-1];
    reg  [LS-1:0] wp_r;
    reg  [TW-1:0] tot_sum_r;
    reg  [DW-1:0] tot_cnt_r;
    reg  [TW-1:0] num_r;
    reg  [DW-1:0] den_r;
    reg  [DW:0]   rem_r;
    reg  [QC-1:0] step_r;
    reg           busy_r;
    integer       i;

    wire [SW-1:0] sum_in  = sum_r + (sample_stb ? {{CW{1'b0}}, sample} : {SW{1'b0}});
    wire [CW-1:0] cnt_in  = cnt_r + {{(CW-1){1'b0}}, sample_stb};
    wire [CW-1:0] dur_m1  = (duration == {CW{1'b0}}) ? {CW{1'b0}} : duration - 1'b1;
    wire          dur_end = sample_stb && (tick_r >= dur_m1);
    wire          p_end   = edge_mode ? period_edge : dur_end;
    wire [TW-1:0] tot_nxt = tot_sum_r - {{LS{1'b0}}, slot_sum[wp_r]} + {{LS{1'b0}}, sum_in};
    wire [DW-1:0] tcn_nxt = tot_cnt_r - {{LS{1'b0}}, slot_cnt[wp_r]} + {{LS{1'b0}}, cnt_in};
    wire [DW:0]   rem_sh  = {rem_r[DW-1:0], num_r[TW-1]};
    wire          sub_ok  = rem_sh >= {1'b0, den_r};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_r     <= {SW{1'b0}};
            cnt_r     <= {CW{1'b0}};
            tick_r    <= {CW{1'b0}};
            wp_r      <= {LS{1'b0}};
            tot_sum_r <= {TW{1'b0}};
            tot_cnt_r <= {DW{1'b0}};
            num_r     <= {TW{1'b0}};
            den_r     <= {DW{1'b0}};
            rem_r     <= {(DW+1){1'b0}};
            step_r    <= {QC{1'b0}};
            busy_r    <= 1'b0;
            avg_r     <= {W{1'b0}};
            peak_r    <= {W{1'b0}};
            for (i = 0; i < SLOTS; i = i + 1) begin
                slot_sum[i] <= {SW{1'b0}};
                slot_cnt[i] <= {CW{1'b0}};
            end
        end else if (ce) begin
            if (clear) begin
                sum_r     <= {SW{1'b0}};
                cnt_r     <= {CW{1'b0}};
                tick_r    <= {CW{1'b0}};
                tot_sum_r <= {TW{1'b0}};
                tot_cnt_r <= {DW{1'b0}};
                busy_r    <= 1'b0;
                avg_r     <= {W{1'b0}};
                peak_r    <= {W{1'b0}};
                for (i = 0; i < SLOTS; i = i + 1) begin
                    slot_sum[i] <= {SW{1'b0}};
                    slot_cnt[i] <= {CW{1'b0}};
                end
            end else begin
                if (p_end) begin
                    // fixed window restarts afresh; sliding keeps the slot ring
                    sum_r  <= {SW{1'b0}};
                    cnt_r  <= {CW{1'b0}};
                    tick_r <= {CW{1'b0}};
                    slot_sum[wp_r] <= sum_in;
                    slot_cnt[wp_r] <= cnt_in;
                    wp_r      <= (wp_r == SLOTS - 1) ? {LS{1'b0}} : wp_r + 1'b1;
                    tot_sum_r <= tot_nxt;
                    tot_cnt_r <= tcn_nxt;
                    // a period ending while the divider runs is dropped
                    if (!busy_r) begin
                        num_r  <= sliding ? tot_nxt : {{LS{1'b0}}, sum_in};
                        den_r  <= sliding ? tcn_nxt : {{LS{1'b0}}, cnt_in};
                        rem_r  <= {(DW+1){1'b0}};
                        step_r <= TW[QC-1:0];
                        busy_r <= sliding ? (tcn_nxt != {DW{1'b0}}) : (cnt_in != {CW{1'b0}});
                    end
                end else begin
                    sum_r <= sum_in;
                    cnt_r <= cnt_in;
                    if (sample_stb) begin
                        tick_r <= tick_r + 1'b1;
                    end
                end
                if (busy_r) begin
                    rem_r  <= sub_ok ? rem_sh - {1'b0, den_r} : rem_sh;
                    num_r  <= {num_r[TW-2:0], sub_ok};
                    step_r <= step_r - 1'b1;
                    if (step_r == {{(QC-1){1'b0}}, 1'b1}) begin
                        busy_r <= 1'b0;
                        avg_r  <= {num_r[W-2:0], sub_ok};
                        if (PEAK != 0 && {num_r[W-2:0], sub_ok} > peak_r) begin
                            peak_r <= {num_r[W-2:0], sub_ok};
                        end
                    end
                end
            end
        end
    end
endmodule // demand_channel

// *** meas_chain_model.sv ***
// behavioural measurement chain
`timescale 1ns/1ps
module meas_chain_model (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         run,
    input  wire [207:0] scene,
    output reg          meas_valid,
    output reg  [207:0] meas
);
    // between samples the lines toggle, so a stale value is never taken as fresh
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_valid <= 1'b0;
            meas       <= 208'h0;
        end else begin
            meas_valid <= run;
            meas       <= run ? scene : ~meas;
        end
    end
endmodule // meas_chain_model

// *** measurement_statistics_unit.v ***
// statistics unit: cutoff display, reference phasor, min/max and demand averages
//
// Notes on behaviour
// - quantities below their cutoff level are shown as exactly zero.
// - cutoff touches only displayed values; recorded values stay unsuppressed.
// - angles are relative to the reference phasor, whose own angle is zero.
// - reference is first voltage channel, falling to next voltage when too small.
// - without usable voltage, phase currents one, two, three become reference in order.
// - min/max restart on their clear, on device reset, or on configuration change.
// - separate sources clear all minima or all maxima on their rising edge.
// - sliding window averages over the most recent SLOTS periods, updated at each period end that finds the divider idle.
// - fixed window clears the running average at each period end.
// - duration option takes period length from a duration setting.
// - edge option averages between successive rising edges of start source.
// - demand values and peaks clear on direct command or source rising edge.
// - three independent channels: current with peak, voltage, power with peak.
`timescale 1ns/1ps
`include "stats_consts.vh"
module measurement_statistics_unit #(
    parameter W     = 16,
    parameter CW    = 16,
    parameter SLOTS = 4
) (
    input  wire                clk,
    input  wire                rst_n,
    input  wire                ce,
    input  wire [7:0]          addr,
    input  wire [31:0]         wdata,
    input  wire                wr_en,
    input  wire                rd_en,
    output reg  [31:0]         rdata,
    input  wire                meas_valid,
    input  wire [W-1:0]        phase_one_voltage,
    input  wire [W-1:0]        phase_two_voltage,
    input  wire [W-1:0]        phase_three_voltage,
    input  wire [W-1:0]        phase_one_current,
    input  wire [W-1:0]        phase_two_current,
    input  wire [W-1:0]        phase_three_current,
    input  wire [W-1:0]        active_power,
    input  wire [W-1:0]        phase_one_voltage_angle,
    input  wire [W-1:0]        phase_two_voltage_angle,
    input  wire [W-1:0]        phase_three_voltage_angle,
    input  wire [W-1:0]        phase_one_current_angle,
    input  wire [W-1:0]        phase_two_current_angle,
    input  wire [W-1:0]        phase_three_current_angle,
    input  wire                clear_minima_source,
    input  wire                clear_maxima_source,
    input  wire                current_period_edge_source,
    input  wire                current_clear_source,
    input  wire                voltage_period_edge_source,
    input  wire                voltage_clear_source,
    input  wire                power_period_edge_source,
    input  wire                power_clear_source,
    output wire [`N_QTY*W-1:0] disp_amp,
    output wire [`N_QTY*W-1:0] rec_amp,
    output wire [`N_QTY*W-1:0] rel_angle,
    output reg  [2:0]          ref_index
);
    // ----------------
    // source synchronisers and edge detection
    // ----------------
    wire [`N_SRC-1:0] src_raw = {power_clear_source, power_period_edge_source,
                                 voltage_clear_source, voltage_period_edge_source,
                                 current_clear_source, current_period_edge_source,
                                 clear_maxima_source, clear_minima_source};

    reg  [`N_SRC-1:0] sync1_r;
    reg  [`N_SRC-1:0] sync2_r;
    reg  [`N_SRC-1:0] sync3_r;

    wire [`N_SRC-1:0] rise = sync2_r & ~sync3_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= {`N_SRC{1'b0}};
            sync2_r <= {`N_SRC{1'b0}};
            sync3_r <= {`N_SRC{1'b0}};
        end else if (ce) begin
            sync1_r <= src_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ----------------
    // register file
    // ----------------
    reg  [1:0]    mode_r [0:2];
    reg  [CW-1:0] dur_r  [0:2];
    reg  [W-1:0]  cut_v_r;
    reg  [W-1:0]  cut_i_r;
    reg  [W-1:0]  ref_min_r;
    reg           vfit_r;

    reg  [4:0]    cmd_r;
    reg           cfg_chg_r;
    integer       j;

    wire          wr_ctl = ce && wr_en;
    wire          cfg_wr = wr_ctl && (addr == `A_CTRL_I || addr == `A_CTRL_V || addr == `A_CTRL_P ||
                                      addr == `A_CUTOFF || addr == `A_REF);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (j = 0; j < 3; j = j + 1) begin
                mode_r[j] <= `CTRL_RST;
                dur_r[j]  <= `DUR_RST;
            end
            cut_v_r   <= `CUT_RST;
            cut_i_r   <= `CUT_RST;
            ref_min_r <= `REFMIN_RST;
            vfit_r    <= `VFIT_RST;
            cmd_r     <= 5'h00;
            cfg_chg_r <= 1'b0;
        end else if (ce) begin
            cmd_r     <= 5'h00;
            cfg_chg_r <= cfg_wr;

            if (wr_en) begin
                case (addr)
                    `A_CTRL_I, `A_CTRL_V, `A_CTRL_P: begin
                        mode_r[addr[3:2]] <= wdata[`B_EDGE:`B_SLIDING];
                        dur_r[addr[3:2]]  <= wdata[`F_DUR +: CW];
                    end

                    `A_CUTOFF: begin
                        cut_v_r <= wdata[W-1:0];
                        cut_i_r <= wdata[`F_CUT_I +: W];
                    end

                    `A_REF: begin
                        ref_min_r <= wdata[W-1:0];
                        vfit_r    <= wdata[`B_VFITTED];
                    end

                    `A_CMD: begin
                        cmd_r <= wdata[4:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------
    // quantity arrays
    // ----------------
    wire [W-1:0] amp [0:`N_MM-1];
    wire [W-1:0] ang [0:`N_QTY-1];
    assign amp[0] = phase_one_voltage;
    assign amp[1] = phase_two_voltage;
    assign amp[2] = phase_three_voltage;
    assign amp[3] = phase_one_current;
    assign amp[4] = phase_two_current;
    assign amp[5] = phase_three_current;
    assign amp[6] = active_power;

    assign ang[0] = phase_one_voltage_angle;
    assign ang[1] = phase_two_voltage_angle;
    assign ang[2] = phase_three_voltage_angle;
    assign ang[3] = phase_one_current_angle;
    assign ang[4] = phase_two_current_angle;
    assign ang[5] = phase_three_current_angle;

    // ----------------
    // reference phasor selection
    // ----------------
    reg  [2:0] ref_c;
    reg        found_c;
    integer    k;

    always @* begin
        // no healthy channel: the previous reference holds
        ref_c   = ref_index;
        found_c = 1'b0;
        for (k = 0; k < `N_QTY; k = k + 1) begin
            // voltages first while fitted, currents after in channel order
            if (!found_c && amp[k] >= ref_min_r && (k >= 3 || vfit_r)) begin
                ref_c   = k[2:0];
                found_c = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_index <= 3'h0;
        end else if (ce && meas_valid) begin
            ref_index <= ref_c;
        end
    end

    // ----------------
    // displayed, recorded and angle outputs
    // ----------------
    reg [W-1:0] disp_r [0:`N_QTY-1];
    reg [W-1:0] rec_r  [0:`N_QTY-1];
    reg [W-1:0] ang_r  [0:`N_QTY-1];

    genvar q;
    generate
        for (q = 0; q < `N_QTY; q = q + 1) begin : g_qty
            wire [W-1:0] cut = (q < 3) ? cut_v_r : cut_i_r;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    disp_r[q] <= {W{1'b0}};
                    rec_r[q]  <= {W{1'b0}};
                    ang_r[q]  <= {W{1'b0}};
                end else if (ce && meas_valid) begin
                    disp_r[q] <= (amp[q] < cut) ? {W{1'b0}} : amp[q];
                    rec_r[q]  <= amp[q];
                    ang_r[q]  <= (ref_c == q) ? {W{1'b0}} : ang[q] - ang[ref_c];
                end
            end

            assign disp_amp[q*W +: W]  = disp_r[q];
            assign rec_amp[q*W +: W]   = rec_r[q];
            assign rel_angle[q*W +: W] = ang_r[q];
        end
    endgenerate

    // ----------------
    // minimum and maximum tracking
    // ----------------
    reg  [W-1:0] min_r [0:`N_MM-1];
    reg  [W-1:0] max_r [0:`N_MM-1];

    // a configuration write restarts the extremes a cycle late
    wire         rst_min = rise[0] | cmd_r[`B_CLR_MIN] | cfg_chg_r;
    wire         rst_max = rise[1] | cmd_r[`B_CLR_MAX] | cfg_chg_r;

    generate
        for (q = 0; q < `N_MM; q = q + 1) begin : g_mm
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    min_r[q] <= {W{1'b1}};
                    max_r[q] <= {W{1'b0}};
                end else if (ce) begin
                    // after a restart the next sample seeds each restarted extreme
                    if (rst_min) begin
                        min_r[q] <= {W{1'b1}};
                    end else if (meas_valid && amp[q] < min_r[q]) begin
                        min_r[q] <= amp[q];
                    end

                    if (rst_max) begin
                        max_r[q] <= {W{1'b0}};
                    end else if (meas_valid && amp[q] > max_r[q]) begin
                        max_r[q] <= amp[q];
                    end
                end
            end
        end
    endgenerate

    // ----------------
    // per-channel period and clear strobes
    // ----------------
    wire [2:0] per_stb = {rise[6], rise[4], rise[2]};
    wire [2:0] clr_stb = {rise[7], rise[5], rise[3]} | cmd_r[`B_CLR_P:`B_CLR_I];

    // ----------------
    // demand channels
    // ----------------
    wire [W-1:0] avg [0:2];
    wire [W-1:0] pk  [0:2];
    wire [W-1:0] dsrc [0:2];
    assign dsrc[0] = phase_one_current;
    assign dsrc[1] = phase_one_voltage;
    assign dsrc[2] = active_power;

    generate
        for (q = 0; q < 3; q = q + 1) begin : g_dem
            demand_channel #(
                .W     (W),
                .CW    (CW),
                .SLOTS (SLOTS),
                .PEAK  ((q == 1) ? 0 : 1)
            ) u_dem (
                .clk         (clk),
                .rst_n       (rst_n),
                .ce          (ce),
                .sample_stb  (meas_valid),
                .sample      (dsrc[q]),
                .sliding     (mode_r[q][`B_SLIDING]),
                .edge_mode   (mode_r[q][`B_EDGE]),
                .duration    (dur_r[q]),
                .period_edge (per_stb[q]),
                .clear       (clr_stb[q]),
                .avg_r       (avg[q]),
                .peak_r      (pk[q])
            );
        end
    endgenerate

    // ----------------
    // read path: data valid only in the cycle after the strobe
    // ----------------
    reg [31:0] rd_c;

    always @* begin
        rd_c = 32'h0000_0000;
        case (addr)
            `A_CTRL_I, `A_CTRL_V, `A_CTRL_P: begin
                rd_c[`B_EDGE:`B_SLIDING] = mode_r[addr[3:2]];
                rd_c[`F_DUR +: CW]       = dur_r[addr[3:2]];
            end
            `A_CUTOFF: begin
                rd_c[W-1:0]       = cut_v_r;
                rd_c[`F_CUT_I +: W] = cut_i_r;
            end
            `A_REF: begin
                rd_c[W-1:0]        = ref_min_r;
                rd_c[`B_VFITTED]   = vfit_r;
            end

            `A_STATUS: rd_c[2:0]  = ref_index;
            `A_AVG_I:  rd_c[W-1:0] = avg[0];
            `A_AVG_V:  rd_c[W-1:0] = avg[1];
            `A_AVG_P:  rd_c[W-1:0] = avg[2];
            `A_PEAK_I: rd_c[W-1:0] = pk[0];
            `A_PEAK_P: rd_c[W-1:0] = pk[2];

            default: begin
                if (addr[7:5] == `PG_MIN && addr[4:2] < `N_MM) begin
                    rd_c[W-1:0] = min_r[addr[4:2]];
                end else if (addr[7:5] == `PG_MAX && addr[4:2] < `N_MM) begin
                    rd_c[W-1:0] = max_r[addr[4:2]];
                end
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= rd_en ? rd_c : 32'h0000_0000;
        end
    end
endmodule // measurement_statistics_unit

// *** stats_consts.vh ***
// register map and reset values of the statistics unit
`ifndef STATS_CONSTS_VH
`define STATS_CONSTS_VH
`define A_CTRL_I     8'h00
`define A_CTRL_V     8'h04
`define A_CTRL_P     8'h08
`define A_CUTOFF     8'h0c
`define A_REF        8'h10
`define A_CMD        8'h14
`define A_STATUS     8'h18
`define A_AVG_I      8'h20
`define A_AVG_V      8'h24
`define A_AVG_P      8'h28
`define A_PEAK_I     8'h2c
`define A_PEAK_P     8'h30
`define PG_MIN       3'h2
`define PG_MAX       3'h3
`define B_SLIDING    0
`define B_EDGE       1
`define F_DUR        16
`define F_CUT_I      16
`define B_VFITTED    16
`define B_CLR_I      0
`define B_CLR_V      1
`define B_CLR_P      2
`define B_CLR_MIN    3
`define B_CLR_MAX    4
`define CTRL_RST     2'h0
`define DUR_RST      16'h0010
`define CUT_RST      16'h0000
`define REFMIN_RST   16'h0010
`define VFIT_RST     1'b1
`define N_QTY        6
`define N_MM         7
`define N_SRC        8
`endif

// *** stats_props.sv ***
// port assertions of the statistics unit
`timescale 1ns/1ps
module stats_props (
    input wire        clk,
    input wire        rst_n,
    input wire        ce,
    input wire        meas_valid,
    input wire [15:0] phase_one_voltage,
    input wire [15:0] phase_two_voltage,
    input wire [15:0] phase_three_voltage,
    input wire [15:0] phase_one_current,
    input wire [15:0] phase_one_voltage_angle,
    input wire [15:0] phase_two_voltage_angle,
    input wire [95:0] disp_amp,
    input wire [95:0] rec_amp,
    input wire [95:0] rel_angle,
    input wire [2:0]  ref_index
);
    // ----------------
    // health threshold kept at its reset value
    // ----------------
    localparam [15:0] HL = 16'h0010;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; ce && meas_valid; endsequence
    sequence s_v1_ok; s_take ##0 (phase_one_voltage >= HL); endsequence
    sequence s_no_v; s_take ##0 (phase_one_voltage < HL && phase_two_voltage < HL && phase_three_voltage < HL);
    endsequence
    chk_cutoff_zero: assert property (disp_amp[15:0] == 16'h0000 || disp_amp[15:0] == rec_amp[15:0])
        else $error("display neither zero nor raw");
    chk_rec_raw: assert property (s_take |=> rec_amp[15:0] == $past(phase_one_voltage))
        else $error("recorded value not raw");
    chk_rec_hold: assert property (!(ce && meas_valid) |=> $stable(rec_amp) && $stable(ref_index))
        else $error("outputs moved without sample");
    chk_ref_zero: assert property (ref_index <= 3'h5 && rel_angle[ref_index*16 +: 16] == 16'h0000)
        else $error("reference angle not zero");
    chk_rel_angle: assert property (s_v1_ok |=>
        rel_angle[31:16] == $past(phase_two_voltage_angle) - $past(phase_one_voltage_angle))
        else $error("relative angle wrong");
    chk_ref_first: assert property (s_v1_ok |=> ref_index == 3'h0)
        else $error("first voltage not reference");
    chk_ref_next: assert property (s_take ##0 (phase_one_voltage < HL && phase_two_voltage >= HL)
        |=> ref_index == 3'h1)
        else $error("second voltage not reference");
    chk_ref_current: assert property (s_no_v ##0 (phase_one_current >= HL) |=> ref_index == 3'h3)
        else $error("first current not reference");
endmodule // stats_props
bind measurement_statistics_unit stats_props chk_u (.clk(clk), .rst_n(rst_n), .ce(ce), .meas_valid(meas_valid),
    .phase_one_voltage(phase_one_voltage), .phase_two_voltage(phase_two_voltage),
    .phase_three_voltage(phase_three_voltage), .phase_one_current(phase_one_current),
    .phase_one_voltage_angle(phase_one_voltage_angle), .phase_two_voltage_angle(phase_two_voltage_angle),
    .disp_amp(disp_amp), .rec_amp(rec_amp), .rel_angle(rel_angle), .ref_index(ref_index));

// *** testbench.sv ***
// self-checking bench of the statistics unit
`timescale 1ns/1ps
`include "stats_consts.vh"
module testbench;
    reg          clk = 1'b0;
    reg          rst_n = 1'b0;
    reg  [7:0]   addr = 8'h00;
    reg  [31:0]  wdata = 32'h0;
    reg          wr_en = 1'b0;
    reg          rd_en = 1'b0;
    reg          run = 1'b0;
    reg  [207:0] scene = 208'h0;
    reg  [7:0]   src = 8'h00;
    wire         meas_valid;
    wire [207:0] m;
    wire [31:0]  rdata;
    wire [95:0]  disp_amp;
    wire [95:0]  rec_amp;
    wire [95:0]  rel_angle;
    wire [2:0]   ref_index;
    integer      error_cnt = 0;
    integer      check_count = 0;
    integer      cyc = 0;
    always #20 clk = ~clk;
    meas_chain_model model_u (.clk(clk), .rst_n(rst_n), .run(run), .scene(scene), .meas_valid(meas_valid), .meas(m));
    measurement_statistics_unit #(.SLOTS(2)) dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .meas_valid(meas_valid),
        .phase_one_voltage(m[15:0]), .phase_two_voltage(m[31:16]), .phase_three_voltage(m[47:32]),
        .phase_one_current(m[63:48]), .phase_two_current(m[79:64]), .phase_three_current(m[95:80]),
        .active_power(m[111:96]), .phase_one_voltage_angle(m[127:112]), .phase_two_voltage_angle(m[143:128]),
        .phase_three_voltage_angle(m[159:144]), .phase_one_current_angle(m[175:160]),
        .phase_two_current_angle(m[191:176]), .phase_three_current_angle(m[207:192]),
        .clear_minima_source(src[0]), .clear_maxima_source(src[1]), .current_period_edge_source(src[2]),
        .current_clear_source(src[3]), .voltage_period_edge_source(src[4]), .voltage_clear_source(src[5]),
        .power_period_edge_source(src[6]), .power_clear_source(src[7]), .disp_amp(disp_amp),
        .rec_amp(rec_amp), .rel_angle(rel_angle), .ref_index(ref_index));
    task stop_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
    end
    task check(input string what, input [31:0] exp, input [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input [7:0] a, input [31:0] exp, input string what);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check(what, exp, rdata);
        @(posedge clk);
    endtask
    // ----------------
    // angles rise by 16'h1000 per channel, v1 first
    // ----------------
    localparam [15:0] z = 16'h0000;
    function [207:0] sc(input [15:0] v1, v2, v3, i1, i2, p);
        sc = {96'h6000_5000_4000_3000_2000_1000, p, i2, i2, i1, v3, v2, v1};
    endfunction
    // long tail lets the 33-cycle divider finish
    task feed(input [207:0] s, input integer n);
        scene <= s;
        run <= 1'b1;
        repeat (n) @(posedge clk);
        run <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    task pulse(input integer b);
        src[b] <= 1'b1;
        repeat (6) @(posedge clk);
        src[b] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    task t_regs;
        rd(`A_CTRL_I, 32'h00100000, "ctrl_i");
        rd(`A_REF, 32'h00010010, "ref_cfg");
        rd(8'h80, 32'h0, "unmapped");
        rd(8'h40, 32'h0000ffff, "min0");
        rd(8'h60, 32'h0, "max0");
    endtask
    task t_cutoff;
        wr(`A_CUTOFF, 32'h00000100);
        feed(sc(16'h0050, 16'h0200, 16'h0200, z, z, z), 1);
        check("disp_v1", 32'h0, disp_amp[15:0]);
        check("disp_v2", 32'h0200, disp_amp[31:16]);
        check("rec_v1", 32'h0050, rec_amp[15:0]);
    endtask
    task t_ref;
        feed(sc(16'h0005, 16'h0100, 16'h0100, z, z, z), 1);
        check("ref_v2", 32'h1, ref_index);
        check("rel_v3", 32'h1000, rel_angle[47:32]);
        feed(sc(16'h0005, 16'h0005, 16'h0005, 16'h0100, 16'h0100, z), 1);
        check("ref_i1", 32'h3, ref_index);
        check("rel_i2", 32'h1000, rel_angle[79:64]);
        feed(sc(16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0100, z), 1);
        check("ref_i2", 32'h4, ref_index);
        rd(`A_STATUS, 32'h4, "status");
    endtask
    task t_minmax;
        wr(`A_CUTOFF, 32'h0);
        rd(8'h60, 32'h0, "max_cfg");
        feed(sc(16'h0100, z, z, z, z, z), 1);
        feed(sc(16'h0300, z, z, z, z, z), 1);
        feed(sc(16'h0200, z, z, z, z, z), 1);
        rd(8'h40, 32'h0100, "min0");
        rd(8'h60, 32'h0300, "max0");
        src[1] <= 1'b1;
        repeat (5) @(posedge clk);
        feed(sc(16'h0150, z, z, z, z, z), 1);
        src[1] <= 1'b0;
        rd(8'h60, 32'h0150, "max_edge");
        rd(8'h40, 32'h0100, "min_kept");
        pulse(0);
        rd(8'h40, 32'h0000ffff, "min_clr");
        wr(`A_CMD, 32'h00000010);
        rd(8'h60, 32'h0, "max_cmd");
    endtask
    task t_fixed;
        do_reset;
        wr(`A_CTRL_I, 32'h00040000);
        wr(`A_CTRL_V, 32'h00040000);
        feed(sc(16'h0100, z, z, 16'h0100, z, z), 4);
        feed(sc(16'h0300, z, z, 16'h0300, z, z), 4);
        feed(sc(16'h0200, z, z, 16'h0200, z, z), 4);
        rd(`A_AVG_I, 32'h0200, "avg_i");
        rd(`A_PEAK_I, 32'h0300, "peak_i");
        wr(`A_CMD, 32'h00000001);
        rd(`A_AVG_I, 32'h0, "avg_i_clr");
        rd(`A_PEAK_I, 32'h0, "peak_i_clr");
        rd(`A_AVG_V, 32'h0200, "avg_v");
    endtask
    task t_sliding;
        do_reset;
        wr(`A_CTRL_I, 32'h00040001);
        feed(sc(z, z, z, 16'h0100, z, z), 4);
        feed(sc(z, z, z, 16'h0300, z, z), 4);
        feed(sc(z, z, z, 16'h0500, z, z), 4);
        rd(`A_AVG_I, 32'h0400, "avg_slide");
    endtask
    task t_edge;
        wr(`A_CTRL_P, 32'h00000002);
        pulse(6);
        feed(sc(z, z, z, z, z, 16'h0040), 2);
        feed(sc(z, z, z, z, z, 16'h0080), 2);
        pulse(6);
        repeat (40) @(posedge clk);
        rd(`A_AVG_P, 32'h0060, "avg_p");
        rd(`A_PEAK_P, 32'h0060, "peak_p");
        pulse(7);
        rd(`A_PEAK_P, 32'h0, "peak_p_clr");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_cutoff;
        t_ref;
        t_minmax;
        t_fixed;
        t_sliding;
        t_edge;
        stop_test;
    end
endmodule // testbench
